// File: design/iedt_defines.svh
// Register offsets, field positions, reset values and timing figures of the
// inertial event debounce block. Assumes inclusion by bare name.
`ifndef IEDT_DEFINES_SVH
`define IEDT_DEFINES_SVH

// ==========================================================================
// Register offsets
`define IEDT_OFS_FF_THS 8'h17
`define IEDT_OFS_FF_CNT 8'h18
`define IEDT_OFS_TR_CFG 8'h1D
`define IEDT_OFS_TR_SRC 8'h1E
`define IEDT_OFS_TR_THS 8'h1F
`define IEDT_OFS_TR_CNT 8'h20

// ==========================================================================
// Field positions
`define IEDT_THS_MODE_BIT 7
`define IEDT_THS_MSB 6
`define IEDT_CFG_LATCH_BIT 4
`define IEDT_CFG_ZEN_BIT 3
`define IEDT_CFG_YEN_BIT 2
`define IEDT_CFG_XEN_BIT 1
`define IEDT_CFG_BYP_BIT 0
`define IEDT_CFG_MSB 4
`define IEDT_SRC_EA_BIT 6

// ==========================================================================
// Reset values
`define IEDT_RST_BYTE 8'h00
`define IEDT_RST_CFG 5'h00
`define IEDT_RST_FLAGS 3'h0

// ==========================================================================
// Threshold limits, 0.063 g per count
`define IEDT_THS_FULL_MAX 7'h7F
`define IEDT_THS_LOWNOISE_MAX 7'h3F

// ==========================================================================
// Oversampling mode codes
`define IEDT_OS_NORMAL 2'h0
`define IEDT_OS_LOW_NOISE_LOW_POWER_MODE 2'h1
`define IEDT_OS_HIRES 2'h2
`define IEDT_OS_LOWPWR 2'h3

// ==========================================================================
// Time step: base 1.25 ms, doubled per rate code up to code 4, capped per mode
`define IEDT_STEP_BASE_US 1250
`define IEDT_CLK_PERIOD_NS 25
`define IEDT_CAP_NORMAL 3'h4
`define IEDT_CAP_LOW_NOISE_LOW_POWER_MODE 3'h6
`define IEDT_CAP_HIRES 3'h1
`define IEDT_CAP_LOWPWR 3'h7

`endif

// File: design/iedt_pkg.sv
// Types shared by the inertial event debounce block.
// Assumes iedt_defines.svh compiled alongside.
package iedt_pkg;

  // ========================================================================
  // Debounce counter state
  typedef struct packed {
    logic [7:0] count;
    logic hit;
  } iedt_dbc_state_type;

  // ========================================================================
  // Step timer state
  typedef struct packed {
    logic [15:0] unit_cnt;
    logic [7:0] mult_cnt;
    logic step;
  } iedt_step_state_type;

  // ========================================================================
  // Top state
  typedef struct packed {
    logic [7:0] ff_ths;
    logic [7:0] ff_cnt;
    logic [4:0] tr_cfg;
    logic [7:0] tr_ths;
    logic [7:0] tr_cnt;
    logic [2:0] tr_flag;
    logic [2:0] tr_pol;
    logic tr_ea;
    logic [2:0] ff_exceed;
    logic [2:0] tr_exceed;
    logic [2:0] tr_sign;
    logic [7:0] rdata;
  } iedt_top_state_type;

endpackage : iedt_pkg

// File: design/iedt_dbc_if.sv
// Carrier between the top and one debounce counter.
// Assumes one clock domain; no clocking block.
interface iedt_dbc_if;
  logic step;
  logic cond;
  logic clear_mode;
  logic clear;
  logic [7:0] target;
  logic [7:0] count;
  logic hit;

  modport ctrl (output step, output cond, output clear_mode, output clear,
    output target, input count, input hit);
  modport dbc (input step, input cond, input clear_mode, input clear,
    input target, output count, output hit);
endinterface : iedt_dbc_if

// File: design/iedt_debounce.sv
// One debounce counter with selectable clear or decrement mode.
// Assumes step is a one-cycle pulse on core_clk.
`include "iedt_defines.svh"
module iedt_debounce
  import iedt_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Control and result
  iedt_dbc_if.dbc bus
);
  import iedt_pkg::*;

  iedt_dbc_state_type st_r;
  iedt_dbc_state_type st_nxt;
  logic [7:0] next_cnt;

  // ========================================================================
  // Count logic
  always_comb begin
    st_nxt = st_r;
    next_cnt = st_r.count;
    if (bus.cond) begin
      if (st_r.count < bus.target) begin
        next_cnt = st_r.count + 8'h01;
      end else begin
        next_cnt = bus.target;
      end
    end else if (bus.clear_mode) begin
      next_cnt = `IEDT_RST_BYTE;
    end else if (st_r.count != `IEDT_RST_BYTE) begin
      next_cnt = st_r.count - 8'h01;
    end
    if (bus.clear) begin
      // A clear restarts the delay before a new event can form
      st_nxt.count = `IEDT_RST_BYTE;
      st_nxt.hit = 1'b0;
    end else if (bus.step) begin
      st_nxt.count = next_cnt;
      st_nxt.hit = bus.cond && (next_cnt == bus.target);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.count = st_r.count;
  assign bus.hit = st_r.hit;

endmodule : iedt_debounce

// File: design/iedt_step_timer.sv
// Debounce time step generator: base period times a power of two.
// Assumes shift is stable between steps; a change takes effect next wrap.
module iedt_step_timer
  import iedt_pkg::*;
#(
  parameter int UNIT_CYCLES = 50000
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Step length as a power of two of the base period
  input wire logic [2:0] shift,
  // One-cycle step pulse
  output logic step
);
  import iedt_pkg::*;

  initial begin
    if (UNIT_CYCLES < 1 || UNIT_CYCLES > 65536) begin
      $error("UNIT_CYCLES out of range");
    end
  end

  localparam logic [15:0] UNIT_LAST = 16'(UNIT_CYCLES - 1);

  iedt_step_state_type st_r;
  iedt_step_state_type st_nxt;
  logic [7:0] mult_last;

  // ========================================================================
  // Two-level divider
  always_comb begin
    st_nxt = st_r;
    mult_last = 8'((9'h001 << shift) - 9'h001);
    st_nxt.step = 1'b0;
    if (st_r.unit_cnt >= UNIT_LAST) begin
      st_nxt.unit_cnt = 16'h0000;
      if (st_r.mult_cnt >= mult_last) begin
        st_nxt.mult_cnt = 8'h00;
        st_nxt.step = 1'b1;
      end else begin
        st_nxt.mult_cnt = st_r.mult_cnt + 8'h01;
      end
    end else begin
      st_nxt.unit_cnt = st_r.unit_cnt + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign step = st_r.step;

endmodule : iedt_step_timer

// File: design/iedt_top.sv
// Freefall/motion and transient debounce logic with its registers.
// Assumes samples come from logic on core_clk and the register port is
// driven by the serial slave on the same clock.
`include "iedt_defines.svh"
module iedt_top
  import iedt_pkg::*;
#(
  parameter int STEP_UNIT_CYCLES = (`IEDT_STEP_BASE_US * 1000) / `IEDT_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Acceleration samples, signed, 0.063 g per count
  input wire logic sample_valid,
  input wire logic signed [7:0] accel_x,
  input wire logic signed [7:0] accel_y,
  input wire logic signed [7:0] accel_z,
  input wire logic signed [7:0] hpf_x,
  input wire logic signed [7:0] hpf_y,
  input wire logic signed [7:0] hpf_z,
  // System settings
  input wire logic [2:0] output_sample_rate,
  input wire logic [1:0] oversample_mode,
  input wire logic low_noise_enable,
  // Freefall/motion configuration
  input wire logic [2:0] ff_axis_enable,
  input wire logic ff_motion_select,
  // Events
  output logic ff_motion_event,
  output logic transient_irq
);
  import iedt_pkg::*;

  initial begin
    if (STEP_UNIT_CYCLES < 1 || STEP_UNIT_CYCLES > 65536) begin
      $error("STEP_UNIT_CYCLES out of range");
    end
  end

  iedt_top_state_type st_r;
  iedt_top_state_type st_nxt;

  iedt_dbc_if ff_dbc ();
  iedt_dbc_if tr_dbc ();

  logic step;
  logic [2:0] step_shift;
  logic [2:0] mode_cap;
  logic [6:0] ff_ths_eff;
  logic [6:0] tr_ths_eff;
  logic ff_cond;
  logic [2:0] tr_en;
  logic src_read;
  logic [7:0] src_view;
  logic [2:0] tr_new_flag;
  logic [2:0] tr_new_pol;

  // ========================================================================
  // Helpers

  // Saturating magnitude: -128 reads as 127 so the full 8 g span is usable
  function automatic logic [6:0] iedt_mag(input logic signed [7:0] v);
    logic [7:0] a;
    a = v[7] ? 8'(-v) : 8'(v);
    if (a[7]) begin
      iedt_mag = `IEDT_THS_FULL_MAX;
    end else begin
      iedt_mag = a[6:0];
    end
  endfunction : iedt_mag

  function automatic logic [6:0] iedt_cap(input logic [6:0] threshold_field, input logic ln);
    if (ln && threshold_field > `IEDT_THS_LOWNOISE_MAX) begin
      iedt_cap = `IEDT_THS_LOWNOISE_MAX;
    end else begin
      iedt_cap = threshold_field;
    end
  endfunction : iedt_cap

  // ========================================================================
  // Time step selection
  always_comb begin
    case (oversample_mode)
      `IEDT_OS_NORMAL: mode_cap = `IEDT_CAP_NORMAL;
      `IEDT_OS_LOW_NOISE_LOW_POWER_MODE: mode_cap = `IEDT_CAP_LOW_NOISE_LOW_POWER_MODE;
      `IEDT_OS_HIRES: mode_cap = `IEDT_CAP_HIRES;
      `IEDT_OS_LOWPWR: mode_cap = `IEDT_CAP_LOWPWR;
      default: mode_cap = `IEDT_CAP_NORMAL;
    endcase
    // Rate codes 0..4 double the step; 5 skips a factor of two, 6 and 7 share one
    case (output_sample_rate)
      3'h5: step_shift = 3'h6;
      3'h6: step_shift = 3'h7;
      3'h7: step_shift = 3'h7;
      default: step_shift = output_sample_rate;
    endcase
    if (step_shift > mode_cap) begin
      step_shift = mode_cap;
    end
  end

  iedt_step_timer #(
    .UNIT_CYCLES(STEP_UNIT_CYCLES)
  ) u_step (
    .core_clk(core_clk),
    .rstn(rstn),
    .shift(step_shift),
    .step(step)
  );

  // ========================================================================
  // Thresholds and conditions
  assign ff_ths_eff = iedt_cap(st_r.ff_ths[`IEDT_THS_MSB:0], low_noise_enable);
  assign tr_ths_eff = iedt_cap(st_r.tr_ths[`IEDT_THS_MSB:0], low_noise_enable);
  assign tr_en = st_r.tr_cfg[`IEDT_CFG_ZEN_BIT:`IEDT_CFG_XEN_BIT];

  always_comb begin
    if (ff_motion_select) begin
      ff_cond = |(st_r.ff_exceed & ff_axis_enable);
    end else begin
      ff_cond = (ff_axis_enable != 3'h0) && !(|(st_r.ff_exceed & ff_axis_enable));
    end
  end

  // ========================================================================
  // Debounce counters
  assign src_read = reg_rd && (reg_addr == `IEDT_OFS_TR_SRC);

  assign ff_dbc.step = step;
  assign ff_dbc.cond = ff_cond;
  assign ff_dbc.clear_mode = st_r.ff_ths[`IEDT_THS_MODE_BIT];
  assign ff_dbc.clear = 1'b0;
  assign ff_dbc.target = st_r.ff_cnt;

  assign tr_dbc.step = step;
  assign tr_dbc.cond = |(st_r.tr_exceed & tr_en);
  assign tr_dbc.clear_mode = st_r.tr_ths[`IEDT_THS_MODE_BIT];
  // Reading the source restarts the delay before a new transient event
  assign tr_dbc.clear = src_read;
  assign tr_dbc.target = st_r.tr_cnt;

  iedt_debounce u_ff_dbc (
    .core_clk(core_clk),
    .rstn(rstn),
    .bus(ff_dbc.dbc)
  );

  iedt_debounce u_tr_dbc (
    .core_clk(core_clk),
    .rstn(rstn),
    .bus(tr_dbc.dbc)
  );

  // ========================================================================
  // Transient source view
  assign tr_new_flag = st_r.tr_exceed & tr_en;
  assign tr_new_pol = st_r.tr_sign & tr_new_flag;

  always_comb begin
    src_view = `IEDT_RST_BYTE;
    src_view[`IEDT_SRC_EA_BIT] = st_r.tr_ea;
    for (int i = 0; i < 3; i++) begin
      src_view[2 * i + 1] = st_r.tr_flag[i];
      src_view[2 * i] = st_r.tr_pol[i];
    end
  end

  // ========================================================================
  // State update
  always_comb begin
    st_nxt = st_r;

    // Sample capture: magnitudes against thresholds, signs for direction
    if (sample_valid) begin
      st_nxt.ff_exceed[0] = iedt_mag(accel_x) > ff_ths_eff;
      st_nxt.ff_exceed[1] = iedt_mag(accel_y) > ff_ths_eff;
      st_nxt.ff_exceed[2] = iedt_mag(accel_z) > ff_ths_eff;
      if (st_r.tr_cfg[`IEDT_CFG_BYP_BIT]) begin
        st_nxt.tr_exceed[0] = iedt_mag(accel_x) > tr_ths_eff;
        st_nxt.tr_exceed[1] = iedt_mag(accel_y) > tr_ths_eff;
        st_nxt.tr_exceed[2] = iedt_mag(accel_z) > tr_ths_eff;
        st_nxt.tr_sign = {accel_z[7], accel_y[7], accel_x[7]};
      end else begin
        st_nxt.tr_exceed[0] = iedt_mag(hpf_x) > tr_ths_eff;
        st_nxt.tr_exceed[1] = iedt_mag(hpf_y) > tr_ths_eff;
        st_nxt.tr_exceed[2] = iedt_mag(hpf_z) > tr_ths_eff;
        st_nxt.tr_sign = {hpf_z[7], hpf_y[7], hpf_x[7]};
      end
    end

    // Source flags; a read clears the active flag even if an event forms that cycle, only the axis flags of that cycle land
    if (st_r.tr_cfg[`IEDT_CFG_LATCH_BIT]) begin
      if (src_read) begin
        st_nxt.tr_ea = 1'b0;
        st_nxt.tr_flag = tr_new_flag;
        st_nxt.tr_pol = tr_new_pol;
      end else if (st_r.tr_ea) begin
        st_nxt.tr_ea = 1'b1;
        st_nxt.tr_flag = st_r.tr_flag | tr_new_flag;
        for (int i = 0; i < 3; i++) begin
          if (tr_new_flag[i]) begin
            st_nxt.tr_pol[i] = tr_new_pol[i];
          end
        end
      end else begin
        st_nxt.tr_ea = tr_dbc.hit;
        st_nxt.tr_flag = tr_new_flag;
        st_nxt.tr_pol = tr_new_pol;
      end
    end else begin
      // Unlatched: live status; the read also clears the counter, so the active flag stays low until a later step sets it again
      st_nxt.tr_ea = tr_dbc.hit && !src_read;
      st_nxt.tr_flag = tr_new_flag;
      st_nxt.tr_pol = tr_new_pol;
    end

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        `IEDT_OFS_FF_THS: st_nxt.ff_ths = reg_wdata;
        `IEDT_OFS_FF_CNT: st_nxt.ff_cnt = reg_wdata;
        `IEDT_OFS_TR_CFG: st_nxt.tr_cfg = reg_wdata[`IEDT_CFG_MSB:0];
        `IEDT_OFS_TR_THS: st_nxt.tr_ths = reg_wdata;
        `IEDT_OFS_TR_CNT: st_nxt.tr_cnt = reg_wdata;
        default: st_nxt.rdata = st_r.rdata;
      endcase
    end

    // Register reads; unmapped offsets read zero
    if (reg_rd) begin
      case (reg_addr)
        `IEDT_OFS_FF_THS: st_nxt.rdata = st_r.ff_ths;
        `IEDT_OFS_FF_CNT: st_nxt.rdata = st_r.ff_cnt;
        `IEDT_OFS_TR_CFG: st_nxt.rdata = {3'h0, st_r.tr_cfg};
        `IEDT_OFS_TR_SRC: st_nxt.rdata = src_view;
        `IEDT_OFS_TR_THS: st_nxt.rdata = st_r.tr_ths;
        `IEDT_OFS_TR_CNT: st_nxt.rdata = st_r.tr_cnt;
        default: st_nxt.rdata = `IEDT_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_r.ff_ths <= `IEDT_RST_BYTE;
      st_r.ff_cnt <= `IEDT_RST_BYTE;
      st_r.tr_cfg <= `IEDT_RST_CFG;
      st_r.tr_ths <= `IEDT_RST_BYTE;
      st_r.tr_cnt <= `IEDT_RST_BYTE;
      st_r.tr_flag <= `IEDT_RST_FLAGS;
      st_r.tr_pol <= `IEDT_RST_FLAGS;
      st_r.tr_ea <= 1'b0;
      st_r.ff_exceed <= `IEDT_RST_FLAGS;
      st_r.tr_exceed <= `IEDT_RST_FLAGS;
      st_r.tr_sign <= `IEDT_RST_FLAGS;
      st_r.rdata <= `IEDT_RST_BYTE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ========================================================================
  // Outputs
  assign reg_rdata = st_r.rdata;
  assign ff_motion_event = ff_dbc.hit;
  assign transient_irq = st_r.tr_ea;

endmodule : iedt_top

// File: testbench/iedt_top_props.sv
// Checker on the ports of iedt_top, attached by bind at the foot.
// Assumes one clock domain and the register map of iedt_defines.svh.
`include "iedt_defines.svh"
module iedt_top_props #(
  parameter int STEP_UNIT_CYCLES = 50000
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Freefall/motion configuration
  input wire logic [2:0] ff_axis_enable,
  input wire logic ff_motion_select,
  // Events
  input wire logic ff_motion_event,
  input wire logic transient_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // ========================================================================
  // Shadows of written registers
  logic [4:0] cfg_r;
  logic [7:0] cnt_r;
  logic src_rd;
  assign src_rd = reg_rd && (reg_addr == `IEDT_OFS_TR_SRC);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_r <= 5'h00;
      cnt_r <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == `IEDT_OFS_TR_CFG) cfg_r <= reg_wdata[4:0];
      if (reg_addr == `IEDT_OFS_FF_CNT) cnt_r <= reg_wdata;
    end
  end
  // ========================================================================
  // Assertions
  a_cfg_readback: assert property (
    reg_rd && !reg_wr && reg_addr == `IEDT_OFS_TR_CFG |=> reg_rdata == {3'h0, cfg_r})
    else $error("config readback differs");
  a_count_readback: assert property (
    reg_rd && !reg_wr && reg_addr == `IEDT_OFS_FF_CNT |=> reg_rdata == cnt_r)
    else $error("count readback differs");
  a_src_top_bit: assert property (src_rd |=> !reg_rdata[7])
    else $error("source bit 7 set");
  a_src_active_irq: assert property (
    src_rd |=> reg_rdata[6] == $past(transient_irq))
    else $error("source active bit differs from irq");
  a_irq_read_clear: assert property (
    src_rd && cfg_r[3:1] == 3'h0 |=> !transient_irq)
    else $error("irq kept after source read");
  a_latch_hold: assert property (
    cfg_r[4] && transient_irq && !src_rd && !reg_wr |=> transient_irq)
    else $error("latched irq dropped without read");
  a_tr_no_axis: assert property (
    (cfg_r[3:1] == 3'h0) [*3] |=> !$rose(transient_irq))
    else $error("transient irq with no axis enabled");
  a_ff_no_axis: assert property (
    (!ff_motion_select && ff_axis_enable == 3'h0) [*4] |=> !$rose(ff_motion_event))
    else $error("freefall event with no axis enabled");
endmodule : iedt_top_props

bind iedt_top iedt_top_props #(.STEP_UNIT_CYCLES(STEP_UNIT_CYCLES)) u_props (
  .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .ff_axis_enable(ff_axis_enable), .ff_motion_select(ff_motion_select),
  .ff_motion_event(ff_motion_event), .transient_irq(transient_irq)
);

// File: testbench/iedt_host.sv
// Host model on the register port: single-byte writes and reads.
// Assumes the device takes a request at the rising edge of core_clk.
module iedt_host (
  // Clock
  input wire logic core_clk,
  // Register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  // Idle lines show the inverse of the last value, so stale data never matches
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    #2;
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(posedge core_clk);
    #2;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~v;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    #2;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge core_clk);
    #2;
    reg_rd = 1'b0;
    reg_addr = ~a;
    v = reg_rdata;
  endtask : rd
endmodule : iedt_host

// File: testbench/iedt_top_tb.sv
// Self-checking bench of iedt_top: register traffic through the host model.
// Assumes header, package, design, checker and host compiled before it.
`include "iedt_defines.svh"
`define CHK(a, e) begin \
  n_tests++; \
  if ((a) !== (e)) begin \
    fail_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); \
  end \
end
module iedt_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // Short step unit keeps the slowest step at 512 cycles
  localparam int UNIT = 4;
  // {offset, write value, expected readback}
  localparam logic [23:0] RWC [4] = '{24'h17FFFF, 24'h1DFF1F, 24'h18A5A5, 24'h1EFF00};
  // {threshold, x, y, z, ctl: en 12:10 select 9 low-noise 8, event}
  localparam logic [47:0] FFC [9] = '{48'h0A0B00001E01, 48'h0A0A00001E00,
    48'h7E7F00001E01, 48'h7E6400001F01, 48'h7E6400001E00, 48'h0A0AF6001C01,
    48'h0A0AF5001C00, 48'h0A0032000600, 48'h0A0000000000};
  // {config, accel x y z, hpf x y z, source}
  localparam logic [63:0] TRC [5] = '{64'h02000000F7000043, 64'h050009000CE00048,
    64'h090000F700000070, 64'h0300000032000000, 64'h0400000032000000};
  // {rate, mode, step shift}
  localparam logic [15:0] RTC [6] = '{16'h0000, 16'h3003, 16'h6004, 16'h6201,
    16'h5106, 16'h6307};
  logic core_clk;
  logic rstn;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic [7:0] reg_wdata;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic sample_valid;
  logic signed [7:0] ax, ay, az, hx, hy, hz;
  logic [2:0] rate;
  logic [1:0] osm;
  logic low_noise;
  logic [2:0] ff_en;
  logic ff_sel;
  logic ff_ev;
  logic tr_irq;
  logic [7:0] d;
  int fail_count;
  int n_tests;
  int n;
  int p;
  iedt_top #(.STEP_UNIT_CYCLES(UNIT)) dut (.core_clk(core_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sample_valid(sample_valid), .accel_x(ax), .accel_y(ay),
    .accel_z(az), .hpf_x(hx), .hpf_y(hy), .hpf_z(hz), .output_sample_rate(rate),
    .oversample_mode(osm), .low_noise_enable(low_noise), .ff_axis_enable(ff_en),
    .ff_motion_select(ff_sel), .ff_motion_event(ff_ev), .transient_irq(tr_irq));
  iedt_host host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  // ========================================================================
  // Tasks
  task automatic step_wait(input int c);
    repeat (c) @(posedge core_clk);
    #2;
  endtask : step_wait
  task automatic smp(input logic [47:0] v);
    @(posedge core_clk);
    #2;
    {ax, ay, az, hx, hy, hz} = v;
    sample_valid = 1'b1;
    @(posedge core_clk);
    #2;
    sample_valid = 1'b0;
  endtask : smp
  task automatic wait_ev(input int lim);
    n = 0;
    while (ff_ev !== 1'b1 && n < lim) begin
      step_wait(1);
      n++;
    end
  endtask : wait_ev
  // One false sample spanning exactly one step, then true again
  task automatic dip();
    smp(48'h0);
    step_wait(2);
    smp(48'h0B0000000000);
    step_wait(7);
  endtask : dip
  task automatic tally_and_finish();
    if (fail_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  // ========================================================================
  // Clock and watchdog
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    fail_count++;
    tally_and_finish();
  end
  // ========================================================================
  // Tests
  initial begin
    rstn = 1'b0;
    sample_valid = 1'b0;
    {ax, ay, az, hx, hy, hz} = 48'h0;
    {rate, osm, low_noise, ff_en, ff_sel} = 10'h000;
    fail_count = 0;
    n_tests = 0;
    repeat (6) @(posedge core_clk);
    #2;
    rstn = 1'b1;
    foreach (RWC[i]) begin
      host.rd(RWC[i][23:16], d);
      `CHK(d, 8'h00)
    end
    host.rd(8'h30, d);
    `CHK(d, 8'h00)
    foreach (RWC[i]) begin
      host.wr(RWC[i][23:16], RWC[i][15:8]);
      host.rd(RWC[i][23:16], d);
      `CHK(d, RWC[i][7:0])
    end
    host.wr(`IEDT_OFS_FF_CNT, 8'h00);
    host.wr(`IEDT_OFS_TR_CFG, 8'h00);
    foreach (FFC[i]) begin
      {ff_en, ff_sel, low_noise} = FFC[i][12:8];
      host.wr(`IEDT_OFS_FF_THS, FFC[i][47:40]);
      smp({FFC[i][39:16], 24'h0});
      step_wait(14);
      `CHK(ff_ev, FFC[i][0])
    end
    {ff_en, ff_sel, low_noise} = 5'h1E;
    host.wr(`IEDT_OFS_FF_CNT, 8'h03);
    host.wr(`IEDT_OFS_FF_THS, 8'h8A);
    smp(48'h0);
    step_wait(14);
    smp(48'h0B0000000000);
    step_wait(8);
    `CHK(ff_ev, 1'b0)
    wait_ev(40);
    `CHK(ff_ev, 1'b1)
    step_wait(12);
    dip();
    `CHK(ff_ev, 1'b0)
    wait_ev(40);
    host.wr(`IEDT_OFS_FF_THS, 8'h0A);
    step_wait(12);
    dip();
    `CHK(ff_ev, 1'b1)
    host.wr(`IEDT_OFS_FF_THS, 8'h8A);
    foreach (RTC[i]) begin
      rate = RTC[i][14:12];
      osm = RTC[i][9:8];
      p = UNIT << RTC[i][7:0];
      smp(48'h0);
      step_wait(1200);
      smp(48'h0B0000000000);
      wait_ev(2000);
      `CHK(n >= 2 * p + 2 && n <= 3 * p + 3, 1'b1)
    end
    // Back to the fastest step so the transient waits below span several steps
    {rate, osm} = 5'h00;
    host.wr(`IEDT_OFS_TR_THS, 8'h05);
    host.wr(`IEDT_OFS_TR_CNT, 8'h00);
    foreach (TRC[i]) begin
      host.wr(`IEDT_OFS_TR_CFG, TRC[i][63:56]);
      smp(TRC[i][55:8]);
      step_wait(12);
      host.rd(`IEDT_OFS_TR_SRC, d);
      step_wait(12);
      host.rd(`IEDT_OFS_TR_SRC, d);
      `CHK(d, TRC[i][7:0])
    end
    host.wr(`IEDT_OFS_TR_CFG, 8'h16);
    smp(48'h000000090000);
    step_wait(12);
    smp(48'h00000000F700);
    step_wait(12);
    smp(48'h0);
    step_wait(12);
    `CHK(tr_irq, 1'b1)
    host.rd(`IEDT_OFS_TR_SRC, d);
    `CHK(d, 8'h4E)
    `CHK(tr_irq, 1'b0)
    host.rd(`IEDT_OFS_TR_SRC, d);
    `CHK(d, 8'h00)
    smp(48'h000000090000);
    step_wait(12);
    host.wr(`IEDT_OFS_TR_CFG, 8'h10);
    step_wait(6);
    `CHK(tr_irq, 1'b1)
    host.rd(`IEDT_OFS_TR_SRC, d);
    `CHK(tr_irq, 1'b0)
    tally_and_finish();
  end
endmodule : iedt_top_tb
